//--- bench/dtm_pin_model.sv
// pin-side partner: drives the capture inputs and the plain port values
`timescale 1ns/1ps
`default_nettype none
module dtm_pin_model (
  // clock
  input  wire logic clk_sys,
  // lines toward the device
  output var  logic first_capture_input,
  output var  logic alternate_capture_input,
  output var  logic port_value_combined,
  output var  logic port_value_wide
);
  initial begin
    first_capture_input     = 1'b0;
    alternate_capture_input = 1'b0;
    port_value_combined     = 1'b0;
    port_value_wide         = 1'b0;
  end
  // levels move just after a rising edge, never while the device samples
  task automatic set_ports(input logic c, input logic w);
    @(posedge clk_sys);
    port_value_combined <= c;
    port_value_wide     <= w;
  endtask : set_ports
  // high pulse of w clocks on one input, then a quiet gap for the filter
  task automatic pulse(input logic sel, input int w);
    @(posedge clk_sys);
    if (sel) begin
      alternate_capture_input <= 1'b1;
    end else begin
      first_capture_input <= 1'b1;
    end
    repeat (w) @(posedge clk_sys);
    first_capture_input     <= 1'b0;
    alternate_capture_input <= 1'b0;
    repeat (30) @(posedge clk_sys);
  endtask : pulse
endmodule : dtm_pin_model
`default_nettype wire

//--- bench/dtm_top_tb_top.sv
// testbench: register accesses and pin traffic against the timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("mismatch at %0t got %h expected %h", $time, \
  got, exp); end end
module dtm_top_tb_top;
  logic        clk_sys;
  logic        reset;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        first_capture_input;
  logic        alternate_capture_input;
  logic        port_value_combined;
  logic        port_value_wide;
  logic        combined_output_pin;
  logic        wide_output_pin;
  logic        wide_capture_irq;
  logic        wide_timeout_irq;
  logic        pin_interrupt_request;
  int          n_mismatch;
  int          check_count;
  int          cyc;
  int          cap_n;
  int          pin_n;
  int          tmo_n;
  int          last_tmo;
  int          period;

  dtm_top i_dut (
    .clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .first_capture_input(first_capture_input),
    .alternate_capture_input(alternate_capture_input),
    .port_value_combined(port_value_combined),
    .port_value_wide(port_value_wide),
    .combined_output_pin(combined_output_pin),
    .wide_output_pin(wide_output_pin),
    .wide_capture_irq(wide_capture_irq),
    .wide_timeout_irq(wide_timeout_irq),
    .pin_interrupt_request(pin_interrupt_request)
  );
  dtm_pin_model i_pin (
    .clk_sys(clk_sys), .first_capture_input(first_capture_input),
    .alternate_capture_input(alternate_capture_input),
    .port_value_combined(port_value_combined),
    .port_value_wide(port_value_wide)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // counts irq pulses and spacing of timeouts; also cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (wide_capture_irq === 1'b1) cap_n++;
    if (pin_interrupt_request === 1'b1) pin_n++;
    if (wide_timeout_irq === 1'b1) begin
      tmo_n++;
      period = cyc - last_tmo;
      last_tmo = cyc;
    end
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // request stands until waitrequest is sampled low at a rising edge;
  // a missing answer is left to the global cycle ceiling
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, {24'h0, e})
  endtask : rd
  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask : settle
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial begin
    reset = 1'b1;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h1;
    writedata = 32'h0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd(dtm_pkg::IDX_COMMON, 8'h00);
    rd(dtm_pkg::IDX_WIDE, 8'h00);
    rd(dtm_pkg::IDX_JOINT, {3'h0, dtm_pkg::JOINT_LOW_ONES});
    rd(dtm_pkg::IDX_WRLD_LO, dtm_pkg::WRLD_RST[7:0]);
    rd(dtm_pkg::IDX_NRLD, dtm_pkg::NRLD_RST);
    rd(4'hf, 8'h00);
    wr(dtm_pkg::IDX_JOINT, 8'h20);
    rd(dtm_pkg::IDX_JOINT, 8'h3f);
    wr(dtm_pkg::IDX_JOINT, 8'h00);
    done("reset_values");
    i_pin.set_ports(1'b1, 1'b1);
    settle();
    `CHK(combined_output_pin, 1'b1)
    `CHK(wide_output_pin, 1'b1)
    i_pin.set_ports(1'b0, 1'b1);
    settle();
    `CHK(combined_output_pin, 1'b0)
    done("port_outputs");
    wr(dtm_pkg::IDX_WIDE, 8'h01);
    for (int lv = 0; lv < 2; lv++) begin
      for (int c = 0; c < 4; c++) begin
        wr(dtm_pkg::IDX_COMMON, 8'h40 | 8'(c << 4) | 8'(lv * 3));
        settle();
        `CHK(combined_output_pin, 1'(c >> 1) ~^ 1'(lv))
        `CHK(wide_output_pin, ~1'(lv))
      end
    end
    wr(dtm_pkg::IDX_COMMON, 8'h48);
    settle();
    `CHK(wide_output_pin, 1'b0)
    wr(dtm_pkg::IDX_COMMON, 8'h4f);
    settle();
    `CHK(wide_output_pin, 1'b1)
    // narrow low level, wide high level; OR shows the narrow output
    wr(dtm_pkg::IDX_COMMON, 8'h51);
    settle();
    `CHK(combined_output_pin, 1'b1)
    wr(dtm_pkg::IDX_JOINT, 8'h40);
    settle();
    `CHK(combined_output_pin, 1'b0)
    rd(dtm_pkg::IDX_JOINT, 8'h5f);
    wr(dtm_pkg::IDX_JOINT, 8'h00);
    done("output_levels");
    wr(dtm_pkg::IDX_COMMON, 8'h00);
    wr(dtm_pkg::IDX_WRLD_LO, 8'h04);
    wr(dtm_pkg::IDX_WRLD_HI, 8'h00);
    for (int d = 0; d < 4; d++) begin
      tmo_n = 0;
      wr(dtm_pkg::IDX_WIDE, 8'h82 | 8'(d << 3));
      for (int n = 0; n < 500 && tmo_n < 3; n++) @(posedge clk_sys);
      `CHK(period, 4 << d)
      wr(dtm_pkg::IDX_WIDE, 8'h20);
    end
    tmo_n = 0;
    wr(dtm_pkg::IDX_WIDE, 8'hc2);
    repeat (60) @(posedge clk_sys);
    `CHK(tmo_n, 1)
    rd(dtm_pkg::IDX_WIDE, 8'h62);
    wr(dtm_pkg::IDX_WIDE, 8'h42);
    rd(dtm_pkg::IDX_WIDE, 8'h62);
    wr(dtm_pkg::IDX_WIDE, 8'h20);
    rd(dtm_pkg::IDX_WIDE, 8'h00);
    done("wide_timer");
    wr(dtm_pkg::IDX_NRLD, 8'h04);
    wr(dtm_pkg::IDX_COMMON, 8'h04);
    wr(dtm_pkg::IDX_WIDE, 8'h42);
    tmo_n = 0;
    wr(dtm_pkg::IDX_JOINT, 8'h40);
    for (int n = 0; n < 200 && tmo_n < 3; n++) @(posedge clk_sys);
    `CHK(period, 8)
    wr(dtm_pkg::IDX_COMMON, 8'h00);
    repeat (40) @(posedge clk_sys);
    tmo_n = 0;
    repeat (40) @(posedge clk_sys);
    `CHK(tmo_n, 0)
    wr(dtm_pkg::IDX_JOINT, 8'h00);
    wr(dtm_pkg::IDX_WIDE, 8'h20);
    done("ping_pong");
    wr(dtm_pkg::IDX_WRLD_LO, 8'hff);
    wr(dtm_pkg::IDX_WRLD_HI, 8'hff);
    wr(dtm_pkg::IDX_COMMON, 8'ha0);
    wr(dtm_pkg::IDX_WIDE, 8'h84);
    cap_n = 0;
    pin_n = 0;
    i_pin.pulse(1'b0, 20);
    `CHK(cap_n, 2)
    `CHK(pin_n, 2)
    rd(dtm_pkg::IDX_COMMON, 8'ha3);
    wr(dtm_pkg::IDX_COMMON, 8'ha3);
    rd(dtm_pkg::IDX_COMMON, 8'ha0);
    wr(dtm_pkg::IDX_COMMON, 8'he0);
    i_pin.pulse(1'b0, 20);
    i_pin.pulse(1'b1, 20);
    `CHK(cap_n, 4)
    `CHK(pin_n, 2)
    // ones in the flag positions clear both flags left by earlier pulses
    wr(dtm_pkg::IDX_COMMON, 8'h97);
    i_pin.pulse(1'b0, 2);
    rd(dtm_pkg::IDX_COMMON, 8'h94);
    i_pin.pulse(1'b0, 12);
    rd(dtm_pkg::IDX_COMMON, 8'h96);
    `CHK(cap_n, 5)
    wr(dtm_pkg::IDX_COMMON, 8'ha3);
    wr(dtm_pkg::IDX_WIDE, 8'h00);
    wr(dtm_pkg::IDX_WIDE, 8'hc4);
    i_pin.pulse(1'b0, 20);
    `CHK(cap_n, 6)
    done("demodulation");
    tally_and_finish();
  end
endmodule : dtm_top_tb_top
`default_nettype wire

//--- rtl/dtm_pkg.sv
// package: register map, field layout, reset values and timing constants
package dtm_pkg;
  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_COMMON   = 4'h1;
  localparam logic [3:0] IDX_WIDE     = 4'h2;
  localparam logic [3:0] IDX_JOINT    = 4'h3;
  localparam logic [3:0] IDX_WRLD_LO  = 4'h4;
  localparam logic [3:0] IDX_WRLD_HI  = 4'h5;
  localparam logic [3:0] IDX_WCAP_LO  = 4'h6;
  localparam logic [3:0] IDX_WCAP_HI  = 4'h7;
  localparam logic [3:0] IDX_NRLD     = 4'h8;
  // common register fields
  localparam int B_MODE = 7;
  localparam int B_SEL  = 6;
  localparam int B_LOGH = 5;
  localparam int B_LOGL = 4;
  localparam int B_SUBH = 3;
  localparam int B_SUBL = 2;
  localparam int B_LV8  = 1;
  localparam int B_LV16 = 0;
  // wide control fields
  localparam int B_EN   = 7;
  localparam int B_SGL  = 6;
  localparam int B_TMO  = 5;
  localparam int B_CLKH = 4;
  localparam int B_CLKL = 3;
  localparam int B_CMSK = 2;
  localparam int B_TMSK = 1;
  localparam int B_PIN  = 0;
  // joint register fields
  localparam int B_JW   = 7;
  localparam int B_JN   = 6;
  localparam int B_SYNC = 5;
  localparam logic [4:0] JOINT_LOW_ONES = 5'h1f;
  // submode and edge codes
  typedef enum logic [1:0] {
    SUB_NORMAL = 2'b00, SUB_PINGPONG = 2'b01,
    SUB_FORCE0 = 2'b10, SUB_FORCE1 = 2'b11
  } dtm_sub_t;
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b10;
  // reset values of reload registers
  localparam logic [15:0] WRLD_RST = 16'hffff;
  localparam logic [7:0]  NRLD_RST = 8'hff;
  // glitch filter widths in system clocks
  localparam int          FILT_SHORT_CLK = 4;
  localparam int          FILT_LONG_CLK  = 8;
  localparam logic [3:0]  FILT_SHORT = 4'(FILT_SHORT_CLK - 1);
  localparam logic [3:0]  FILT_LONG  = 4'(FILT_LONG_CLK - 1);
endpackage : dtm_pkg

//--- rtl/dtm_top.sv
// module: dual timer mode control with avalon register slave
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module dtm_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // avalon-mm slave, word addressed
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // port pins
  input  wire logic        first_capture_input,
  input  wire logic        alternate_capture_input,
  input  wire logic        port_value_combined,
  input  wire logic        port_value_wide,
  output logic             combined_output_pin,
  output logic             wide_output_pin,
  // interrupt requests, one-cycle pulses
  output logic             wide_capture_irq,
  output logic             wide_timeout_irq,
  output logic             pin_interrupt_request
);
  logic [7:0]  common_q;
  logic        rise_q, fall_q, lv8_q, lv16_q;
  logic [7:0]  wctl_q;
  logic        wen_q, wtmo_q, sync_q, nen_q;
  logic [15:0] wrld_q, wcnt_q, wcap_q;
  logic [7:0]  nrld_q, ncnt_q;
  logic        wout_q, nout_q, wseen_q;
  logic        wait_q;
  logic [7:0]  rdat_q;
  logic [2:0]  pre_q;
  logic        raw_in, filt_q, prev_q;
  logic [3:0]  fcnt_q;
  logic        cap_irq_q, tmo_irq_q, pin_irq_q, comb_q, wpin_q;
  logic        tx, wr_acc, wtick, rise_det, fall_det, edge_det;
  logic        wtc, ntc, capture, wstart, nstart, wstop, nstop;
  logic        pingpong;
  logic [1:0]  sub;
  logic [3:0]  flen;
  logic [7:0]  wd, rmux;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  assign tx       = !common_q[dtm_pkg::B_MODE];
  assign sub      = common_q[dtm_pkg::B_SUBH:dtm_pkg::B_SUBL];
  assign pingpong = tx && (sub == dtm_pkg::SUB_PINGPONG);
  assign wd       = writedata[7:0];
  assign wr_acc   = write && !wait_q && byteenable[0];

  // avalon: one wait cycle, then the transfer completes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_q <= 1'b1;
      rdat_q <= 8'h00;
    end else if ((read || write) && wait_q) begin
      wait_q <= 1'b0;
      rdat_q <= rmux;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_comb begin
    rmux = 8'h00;
    unique case (address)
      dtm_pkg::IDX_COMMON:
        rmux = tx ? common_q :
               {common_q[7:2], rise_q, fall_q};
      dtm_pkg::IDX_WIDE:
        rmux = {wen_q, wctl_q[6], wtmo_q, wctl_q[4:0]};
      dtm_pkg::IDX_JOINT:
        rmux = {wen_q, nen_q, sync_q, dtm_pkg::JOINT_LOW_ONES};
      dtm_pkg::IDX_WRLD_LO: rmux = wrld_q[7:0];
      dtm_pkg::IDX_WRLD_HI: rmux = wrld_q[15:8];
      dtm_pkg::IDX_WCAP_LO: rmux = wcap_q[7:0];
      dtm_pkg::IDX_WCAP_HI: rmux = wcap_q[15:8];
      dtm_pkg::IDX_NRLD:    rmux = nrld_q;
      default:              rmux = 8'h00;
    endcase
  end

  // common register; level bits share positions with the edge flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      common_q <= 8'h00;
    end else if (wr_acc && address == dtm_pkg::IDX_COMMON) begin
      common_q <= wd;
    end
  end
  assign lv8_q  = common_q[dtm_pkg::B_LV8];
  assign lv16_q = common_q[dtm_pkg::B_LV16];

  // edge flags: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      if (!tx && rise_det && edge_det)
        rise_q <= 1'b1;
      else if (wr_acc && address == dtm_pkg::IDX_COMMON && wd[dtm_pkg::B_LV8])
        rise_q <= 1'b0;
      if (!tx && fall_det && edge_det)
        fall_q <= 1'b1;
      else if (wr_acc && address == dtm_pkg::IDX_COMMON && wd[dtm_pkg::B_LV16])
        fall_q <= 1'b0;
    end
  end

  // wide control, reload and narrow reload registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wctl_q <= 8'h00;
      wrld_q <= dtm_pkg::WRLD_RST;
      nrld_q <= dtm_pkg::NRLD_RST;
      sync_q <= 1'b0;
    end else if (wr_acc) begin
      unique case (address)
        dtm_pkg::IDX_WIDE:    wctl_q <= wd;
        dtm_pkg::IDX_WRLD_LO: wrld_q[7:0] <= wd;
        dtm_pkg::IDX_WRLD_HI: wrld_q[15:8] <= wd;
        dtm_pkg::IDX_NRLD:    nrld_q <= wd;
        dtm_pkg::IDX_JOINT:   sync_q <= wd[dtm_pkg::B_SYNC];
        default: ;
      endcase
    end
  end

  // enable writes from either the wide or the joint register
  always_comb begin
    wstart = 1'b0;
    wstop  = 1'b0;
    nstart = 1'b0;
    nstop  = 1'b0;
    if (wr_acc && address == dtm_pkg::IDX_WIDE) begin
      wstart = wd[dtm_pkg::B_EN] && !wen_q;
      wstop  = !wd[dtm_pkg::B_EN];
    end
    if (wr_acc && address == dtm_pkg::IDX_JOINT) begin
      wstart = wd[dtm_pkg::B_JW] && !wen_q;
      wstop  = !wd[dtm_pkg::B_JW];
      nstart = wd[dtm_pkg::B_JN] && !nen_q;
      nstop  = !wd[dtm_pkg::B_JN];
    end
    // ping-pong hands the run from one counter to the other
    if (pingpong && ntc && !nstop && !wstop)
      wstart = 1'b1;
    if (pingpong && wtc && !wstop)
      nstart = 1'b1;
  end

  // prescaler; sync mode restarts it on a joint enable write
  always_ff @(posedge clk_sys) begin
    if (reset)
      pre_q <= 3'h0;
    else if (sync_q && wr_acc && address == dtm_pkg::IDX_JOINT)
      pre_q <= 3'h0;
    else
      pre_q <= pre_q + 3'h1;
  end

  always_comb begin
    unique case (wctl_q[dtm_pkg::B_CLKH:dtm_pkg::B_CLKL])
      2'b00: wtick = 1'b1;
      2'b01: wtick = pre_q[0];
      2'b10: wtick = &pre_q[1:0];
      2'b11: wtick = &pre_q;
    endcase
  end

  // glitch filter: input must hold the new level for the chosen width
  assign raw_in = common_q[dtm_pkg::B_SEL] ? alternate_capture_input
                                           : first_capture_input;
  always_comb begin
    unique case (sub)
      2'b01:   flen = dtm_pkg::FILT_SHORT;
      2'b10:   flen = dtm_pkg::FILT_LONG;
      default: flen = 4'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      filt_q <= 1'b0;
      fcnt_q <= 4'h0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= filt_q;
      if (raw_in == filt_q) begin
        fcnt_q <= 4'h0;
      end else if (fcnt_q >= flen) begin
        filt_q <= raw_in;
        fcnt_q <= 4'h0;
      end else begin
        fcnt_q <= fcnt_q + 4'h1;
      end
    end
  end

  assign rise_det = filt_q && !prev_q;
  assign fall_det = !filt_q && prev_q;
  always_comb begin
    unique case (common_q[dtm_pkg::B_LOGH:dtm_pkg::B_LOGL])
      dtm_pkg::EDGE_FALL: edge_det = fall_det;
      dtm_pkg::EDGE_RISE: edge_det = rise_det;
      dtm_pkg::EDGE_BOTH: edge_det = rise_det || fall_det;
      default:            edge_det = 1'b0;
    endcase
  end

  // reserved edge code reports nothing; single mode ignores later edges
  assign capture = !tx && wen_q && edge_det &&
                   (!wseen_q || !wctl_q[dtm_pkg::B_SGL]);
  assign wtc = wen_q && wtick && (wcnt_q == 16'h0001) &&
               (tx || wseen_q);

  // wide counter; zero start rolls over without a timeout
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wen_q   <= 1'b0;
      wcnt_q  <= 16'h0000;
      wcap_q  <= 16'h0000;
      wseen_q <= 1'b0;
    end else if (wstop) begin
      wen_q   <= 1'b0;
      wseen_q <= 1'b0;
    end else if (wstart) begin
      wen_q   <= 1'b1;
      wseen_q <= 1'b0;
      wcnt_q  <= wrld_q;
    end else if (capture) begin
      wcap_q  <= ~wcnt_q;
      wcnt_q  <= wrld_q;
      wseen_q <= 1'b1;
    end else if (wtc && tx) begin
      if (wctl_q[dtm_pkg::B_SGL] || pingpong)
        wen_q <= 1'b0;
      else
        wcnt_q <= wrld_q;
    end else if (wen_q && wtick && (tx || wseen_q)) begin
      wcnt_q <= wcnt_q - 16'h0001;
    end
  end

  // timeout flag: terminal count wins over a clear
  always_ff @(posedge clk_sys) begin
    if (reset)
      wtmo_q <= 1'b0;
    else if (wtc)
      wtmo_q <= 1'b1;
    else if (wr_acc && address == dtm_pkg::IDX_WIDE && wd[dtm_pkg::B_TMO])
      wtmo_q <= 1'b0;
  end

  // wide output level
  always_ff @(posedge clk_sys) begin
    if (reset)
      wout_q <= 1'b1;
    else if (tx && sub == dtm_pkg::SUB_FORCE0)
      wout_q <= 1'b0;
    else if (tx && sub == dtm_pkg::SUB_FORCE1)
      wout_q <= 1'b1;
    else if (wstart)
      wout_q <= lv16_q;
    else if (!wen_q)
      wout_q <= !lv16_q;
    else if (wtc && tx)
      wout_q <= !wout_q;
  end

  // narrow counter, transmit only, counts on every system clock
  assign ntc = nen_q && tx && (ncnt_q == 8'h01);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nen_q  <= 1'b0;
      ncnt_q <= 8'h00;
    end else if (nstop) begin
      nen_q <= 1'b0;
    end else if (nstart) begin
      nen_q  <= 1'b1;
      ncnt_q <= nrld_q;
    end else if (ntc) begin
      if (pingpong)
        nen_q <= 1'b0;
      else
        ncnt_q <= nrld_q;
    end else if (nen_q && tx) begin
      ncnt_q <= ncnt_q - 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset)
      nout_q <= 1'b1;
    else if (nstart)
      nout_q <= lv8_q;
    else if (!nen_q)
      nout_q <= !lv8_q;
    else if (ntc)
      nout_q <= !nout_q;
  end

  // pins and interrupt requests, all registered
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      comb_q    <= 1'b0;
      wpin_q    <= 1'b0;
      cap_irq_q <= 1'b0;
      tmo_irq_q <= 1'b0;
      pin_irq_q <= 1'b0;
    end else begin
      if (tx && common_q[dtm_pkg::B_SEL]) begin
        unique case (common_q[dtm_pkg::B_LOGH:dtm_pkg::B_LOGL])
          2'b00: comb_q <= nout_q & wout_q;
          2'b01: comb_q <= nout_q | wout_q;
          2'b10: comb_q <= ~(nout_q | wout_q);
          2'b11: comb_q <= ~(nout_q & wout_q);
        endcase
      end else begin
        comb_q <= port_value_combined;
      end
      wpin_q    <= wctl_q[dtm_pkg::B_PIN] ? wout_q
                                          : port_value_wide;
      cap_irq_q <= capture && wctl_q[dtm_pkg::B_CMSK];
      tmo_irq_q <= wtc && wctl_q[dtm_pkg::B_TMSK];
      pin_irq_q <= capture && !common_q[dtm_pkg::B_SEL];
    end
  end

  assign readdata              = {24'h000000, rdat_q};
  assign waitrequest           = wait_q;
  assign combined_output_pin   = comb_q;
  assign wide_output_pin       = wpin_q;
  assign wide_capture_irq      = cap_irq_q;
  assign wide_timeout_irq      = tmo_irq_q;
  assign pin_interrupt_request = pin_irq_q;

  sequence s_forced_lo;
    tx && sub == dtm_pkg::SUB_FORCE0 ##1 tx && sub == dtm_pkg::SUB_FORCE0;
  endsequence
  sequence s_idle8;
    (tx && !nen_q && !nstart && $stable(lv8_q)) [*2];
  endsequence

  a_bus_answer: assert property ((read || write) && wait_q |=> !wait_q)
    else $error("bus request not answered");
  a_joint_ones: assert property (read && !wait_q &&
      address == dtm_pkg::IDX_JOINT |-> rdat_q[4:0] == 5'h1f)
    else $error("joint low bits not ones");
  a_forced_low: assert property (s_forced_lo |-> !wout_q)
    else $error("wide output not forced low");
  a_idle_level8: assert property (s_idle8 |-> nout_q == !lv8_q)
    else $error("narrow idle level wrong");
  a_start_level: assert property (wstart && tx && sub[1] == 1'b0 |=>
      wout_q == $past(lv16_q) && wen_q)
    else $error("wide start level wrong");
  a_tmo_clear: assert property (wr_acc && address == dtm_pkg::IDX_WIDE &&
      wd[dtm_pkg::B_TMO] && !wtc |=> !wtmo_q)
    else $error("timeout flag not cleared");
  a_cap_irq: assert property (capture && wctl_q[dtm_pkg::B_CMSK] |=>
      cap_irq_q ##1 (!cap_irq_q || $past(capture)))
    else $error("capture request missing");
  a_rise_flag: assert property (!tx && rise_det && edge_det |=> rise_q)
    else $error("rise flag not set");
  a_div8_tick: assert property (wtick && wctl_q[4:3] == 2'b11 && !sync_q
      |=> (!wtick || wctl_q[4:3] != 2'b11) [*7])
    else $error("divide by eight spacing wrong");
endmodule : dtm_top
`default_nettype wire
